//--- core/plcx_port.sv
// plcx_port: one byte-wide port, output latch and pin synchroniser
// assumes pin levels arrive asynchronously to clk
`timescale 1ns/100ps
`default_nettype none
`include "plcx_defs.svh"

module plcx_port
(
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             wr_en,
  input  wire plcx_pkg::plcx_byte_t wr_data,
  input  wire plcx_pkg::plcx_byte_t pin_in,
  output var  plcx_pkg::plcx_byte_t latch_reg,
  output var  plcx_pkg::plcx_byte_t pin_sync_reg
);

  plcx_pkg::plcx_byte_t pin_meta_reg;
  plcx_pkg::plcx_byte_t latch_next;

  assign latch_next = wr_en ? wr_data : latch_reg;

  // -------------------------------------------------------------
  // output latch holds until next write
  // -------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      latch_reg <= `PLCX_PORT_RESET;
    else
      latch_reg <= latch_next;
  end

  // -------------------------------------------------------------
  // two-flop pin synchroniser
  // -------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 8'h00;
      pin_sync_reg <= 8'h00;
    end
    else
    begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

endmodule

`default_nettype wire

//--- core/plcx_top.sv
// plcx_top: four general-purpose ports and the second routing control register
// assumes the cpu drives the sfr strobes for one cycle, synchronous to clk
//
// Overview of operation
// - four eight-bit ports, each bit in or out
// - ports byte and bit addressable, single bit only
// - writes go to latch, latch drives outputs
// - plain reads return synchronised pin levels
// - listed instructions count as read-modify-write
// - read-modify-write reads latch, writes result back
// - unpinned ports keep fully working registers
// - weak pull-ups enabled after reset
`timescale 1ns/100ps
`default_nettype none
`include "plcx_defs.svh"

module plcx_top
(
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic [7:0]           sfr_addr,
  input  wire logic                 sfr_bit_mode,
  input  wire logic                 sfr_wr,
  input  wire plcx_pkg::plcx_byte_t sfr_wdata,
  input  wire logic                 sfr_rd,
  input  wire logic                 sfr_rmw,
  output var  plcx_pkg::plcx_byte_t sfr_rdata_reg,
  input  wire plcx_pkg::plcx_byte_t port0_pin,
  input  wire plcx_pkg::plcx_byte_t port1_pin,
  input  wire plcx_pkg::plcx_byte_t port2_pin,
  input  wire plcx_pkg::plcx_byte_t port3_pin,
  output var  plcx_pkg::plcx_byte_t port0_out_reg,
  output var  plcx_pkg::plcx_byte_t port1_out_reg,
  output var  plcx_pkg::plcx_byte_t port2_out_reg,
  output var  plcx_pkg::plcx_byte_t port3_out_reg,
  output var  logic                 weak_pullup_en_reg,
  output var  logic                 routing_matrix_enable_reg,
  output var  logic                 conversion_start_pin_enable_reg
);

  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  wire logic [7:0]              byte_addr;
  wire plcx_pkg::plcx_bit_idx_t bit_idx;
  wire plcx_pkg::plcx_byte_t    bit_mask;
  wire plcx_pkg::plcx_byte_t    port_addr [0:3];
  wire plcx_pkg::plcx_byte_t    port_pin  [0:3];
  wire plcx_pkg::plcx_byte_t    port_latch [0:3];
  wire plcx_pkg::plcx_byte_t    port_sync  [0:3];
  wire plcx_pkg::plcx_byte_t    port_wdata [0:3];
  wire plcx_pkg::plcx_byte_t    port_rbyte [0:3];
  wire logic [3:0]              port_hit;
  wire logic                    route_hit;
  wire plcx_pkg::plcx_byte_t    route_b_value;
  plcx_pkg::plcx_byte_t         route_b_reg;
  plcx_pkg::plcx_byte_t         route_b_next;
  plcx_pkg::plcx_byte_t         rdata_next;

  assign byte_addr = sfr_bit_mode ? {sfr_addr[7:3], 3'h0} : sfr_addr;
  assign bit_idx   = sfr_addr[2:0];
  assign bit_mask  = 8'h01 << bit_idx;

  assign port_addr[0] = `PLCX_PORT0_ADDR;
  assign port_addr[1] = `PLCX_PORT1_ADDR;
  assign port_addr[2] = `PLCX_PORT2_ADDR;
  assign port_addr[3] = `PLCX_PORT3_ADDR;
  assign port_pin[0]  = port0_pin;
  assign port_pin[1]  = port1_pin;
  assign port_pin[2]  = port2_pin;
  assign port_pin[3]  = port3_pin;

  // control register is byte addressable only
  assign route_hit     = !sfr_bit_mode && (sfr_addr == `PLCX_ROUTE_B_ADDR);
  assign route_b_value = route_b_reg & `PLCX_ROUTE_B_MASK;
  assign route_b_next  = (sfr_wr && route_hit) ? (sfr_wdata & `PLCX_ROUTE_B_MASK) : route_b_reg;

  // -------------------------------------------------------------
  // the four ports
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `PLCX_NUM_PORTS; gi = gi + 1)
    begin : g_port
      assign port_hit[gi] = (byte_addr == port_addr[gi]);
      // bit write merges into the latch, leaving other bits alone
      assign port_wdata[gi] = sfr_bit_mode
        ? ((port_latch[gi] & ~bit_mask) | (sfr_wdata[0] ? bit_mask : 8'h00))
        : sfr_wdata;
      // read-modify-write reads latch, else pin level
      assign port_rbyte[gi] = sfr_rmw ? port_latch[gi] : port_sync[gi];
      plcx_port u_port
      (
        .clk          (clk),
        .reset_n      (reset_n),
        .wr_en        (sfr_wr && port_hit[gi]),
        .wr_data      (port_wdata[gi]),
        .pin_in       (port_pin[gi]),
        .latch_reg    (port_latch[gi]),
        .pin_sync_reg (port_sync[gi])
      );
    end
  endgenerate

  // -------------------------------------------------------------
  // read data select
  // -------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    for (int i = 0; i < `PLCX_NUM_PORTS; i++)
    begin
      if (port_hit[i])
        rdata_next = sfr_bit_mode ? {7'h00, port_rbyte[i][bit_idx]} : port_rbyte[i];
    end
    if (route_hit)
      rdata_next = route_b_value;
  end

  // -------------------------------------------------------------
  // registers and outputs
  // -------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      route_b_reg <= `PLCX_ROUTE_B_RESET;
    else
      route_b_reg <= route_b_next;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      sfr_rdata_reg <= 8'h00;
    else if (sfr_rd)
      sfr_rdata_reg <= rdata_next;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      weak_pullup_en_reg              <= 1'b1;
      routing_matrix_enable_reg       <= 1'b0;
      conversion_start_pin_enable_reg <= 1'b0;
      port0_out_reg                   <= `PLCX_PORT_RESET;
      port1_out_reg                   <= `PLCX_PORT_RESET;
      port2_out_reg                   <= `PLCX_PORT_RESET;
      port3_out_reg                   <= `PLCX_PORT_RESET;
    end
    else
    begin
      weak_pullup_en_reg              <= !route_b_next[`PLCX_WPUD_BIT];
      routing_matrix_enable_reg       <= route_b_next[`PLCX_XBAR_BIT];
      conversion_start_pin_enable_reg <= route_b_next[`PLCX_CNVST_BIT];
      port0_out_reg                   <= sfr_wr && port_hit[0] ? port_wdata[0] : port_latch[0];
      port1_out_reg                   <= sfr_wr && port_hit[1] ? port_wdata[1] : port_latch[1];
      port2_out_reg                   <= sfr_wr && port_hit[2] ? port_wdata[2] : port_latch[2];
      port3_out_reg                   <= sfr_wr && port_hit[3] ? port_wdata[3] : port_latch[3];
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  AST_OUT_FOLLOWS_LATCH: assert property (@(posedge clk) disable iff (!reset_n)
    (port0_out_reg == port_latch[0]) && (port3_out_reg == port_latch[3]))
    else $error("port output differs from latch");

  AST_BYTE_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_wr && !sfr_bit_mode && sfr_addr == `PLCX_PORT1_ADDR)
      |=> (port1_out_reg == $past(sfr_wdata)))
    else $error("byte write not latched");

  AST_LATCH_HOLD: assert property (@(posedge clk) disable iff (!reset_n)
    !(sfr_wr && port_hit[2]) |=> $stable(port2_out_reg))
    else $error("latch changed without write");

  AST_BIT_WRITE: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_wr && sfr_bit_mode && port_hit[0])
      |=> ((port0_out_reg & ~$past(bit_mask)) == ($past(port_latch[0]) & ~$past(bit_mask)))
          && (port0_out_reg[$past(bit_idx)] == $past(sfr_wdata[0])))
    else $error("bit write disturbed other bits");

  AST_PIN_READ: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_rd && !sfr_rmw && !sfr_bit_mode && port_hit[1])
      |=> (sfr_rdata_reg == $past(port_sync[1])))
    else $error("plain read not from pins");

  AST_RMW_READ: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_rd && sfr_rmw && !sfr_bit_mode && port_hit[2])
      |=> (sfr_rdata_reg == $past(port_latch[2])))
    else $error("rmw read not from latch");

  AST_UNPINNED_RW: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_wr && !sfr_bit_mode && sfr_addr == `PLCX_PORT3_ADDR)
      ##1 (sfr_rd && sfr_rmw && !sfr_wr && !sfr_bit_mode && sfr_addr == `PLCX_PORT3_ADDR)
      |=> (sfr_rdata_reg == $past(sfr_wdata, 2)))
    else $error("unpinned port does not read back");

  AST_PULLUP_RESET: assert property (@(posedge clk)
    !reset_n |=> weak_pullup_en_reg && !routing_matrix_enable_reg)
    else $error("pull-ups not enabled after reset");

  AST_QUAL_SELECT: assert property (@(posedge clk) disable iff (!reset_n)
    (sfr_rd && sfr_bit_mode && port_hit[0])
      |=> sfr_rdata_reg == {7'h00, $past(sfr_rmw) ? $past(port_latch[0][bit_idx])
                                                   : $past(port_sync[0][bit_idx])})
    else $error("bit read source wrong");

  COV_RMW: cover property (@(posedge clk) disable iff (!reset_n)
    sfr_rd && sfr_rmw && sfr_wr && (port_hit != 4'h0));
  COV_BIT_SET: cover property (@(posedge clk) disable iff (!reset_n)
    sfr_wr && sfr_bit_mode && sfr_wdata[0] && port_hit[3]);
  COV_PULLUP_OFF: cover property (@(posedge clk) disable iff (!reset_n)
    $fell(weak_pullup_en_reg));

endmodule

`default_nettype wire

//--- inc/plcx_defs.svh
// plcx_defs.svh: register offsets, field positions and reset values of the port block
// assumes the 8051-style special function register address space
`ifndef PLCX_DEFS_SVH
`define PLCX_DEFS_SVH

`define PLCX_PORT0_ADDR    8'h80
`define PLCX_PORT1_ADDR    8'h90
`define PLCX_PORT2_ADDR    8'ha0
`define PLCX_PORT3_ADDR    8'hb0
`define PLCX_ROUTE_B_ADDR  8'he3

`define PLCX_PORT_RESET    8'hff
`define PLCX_ROUTE_B_RESET 8'h00
`define PLCX_ROUTE_B_MASK  8'hc1

`define PLCX_WPUD_BIT      7
`define PLCX_XBAR_BIT      6
`define PLCX_CNVST_BIT     0

`define PLCX_NUM_PORTS     4

`endif

//--- inc/plcx_pkg.sv
// plcx_pkg: types shared by the port block
// assumes plcx_defs.svh is compiled alongside
package plcx_pkg;
  typedef logic [7:0] plcx_byte_t;
  typedef logic [2:0] plcx_bit_idx_t;
endpackage

//--- testbench/plcx_pin_model.sv
// plcx_pin_model: pins around the port block
// assumes latches drive their pins unless a far driver overrides port0
`timescale 1ns/100ps
`default_nettype none

module plcx_pin_model
(
  input  wire logic                 ext_en,
  input  wire plcx_pkg::plcx_byte_t ext_val,
  input  wire plcx_pkg::plcx_byte_t out0,
  input  wire plcx_pkg::plcx_byte_t out1,
  input  wire plcx_pkg::plcx_byte_t out2,
  input  wire plcx_pkg::plcx_byte_t out3,
  output wire plcx_pkg::plcx_byte_t pin0,
  output wire plcx_pkg::plcx_byte_t pin1,
  output wire plcx_pkg::plcx_byte_t pin2,
  output wire plcx_pkg::plcx_byte_t pin3
);
  // far driver may overpower port0
  assign pin0 = ext_en ? ext_val : out0;
  assign pin1 = out1;
  // unpinned ports held by push-pull drivers
  assign pin2 = out2;
  assign pin3 = out3;
endmodule

`default_nettype wire

//--- testbench/plcx_top_bench.sv
// plcx_top_bench: register access tests of the port block
// assumes the pin model loops the latches back to the pins
`timescale 1ns/100ps
`default_nettype none

module plcx_top_bench;
  logic clk, reset_n, bm, wr, rd, rmw, ext_en, wpu, xbe, cse;
  logic [7:0] addr, wd, ext_val, rdata, o0, o1, o2, o3, p0, p1, p2, p3;
  int errors = 0;
  int n_compared = 0;

  plcx_top DUT
  (
    .clk(clk), .reset_n(reset_n), .sfr_addr(addr), .sfr_bit_mode(bm),
    .sfr_wr(wr), .sfr_wdata(wd), .sfr_rd(rd), .sfr_rmw(rmw),
    .sfr_rdata_reg(rdata), .port0_pin(p0), .port1_pin(p1),
    .port2_pin(p2), .port3_pin(p3), .port0_out_reg(o0),
    .port1_out_reg(o1), .port2_out_reg(o2), .port3_out_reg(o3),
    .weak_pullup_en_reg(wpu), .routing_matrix_enable_reg(xbe),
    .conversion_start_pin_enable_reg(cse)
  );

  plcx_pin_model pins
  (
    .ext_en(ext_en), .ext_val(ext_val), .out0(o0), .out1(o1), .out2(o2),
    .out3(o3), .pin0(p0), .pin1(p1), .pin2(p2), .pin3(p3)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // one access; entered and left just after a rising edge
  // strobes stand until the next access or idle replaces them
  task automatic acc(input logic [7:0] a, input logic b, w, r, m, input logic [7:0] d);
    addr = a;
    bm = b;
    wr = w;
    rd = r;
    rmw = m;
    wd = d;
    @(posedge clk);
    #1;
  endtask

  // drops the strobes, then lets n edges pass
  task automatic idle(input int n);
    wr = 0;
    rd = 0;
    rmw = 0;
    bm = 0;
    repeat (n) @(posedge clk);
    #1;
  endtask

  task tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------
  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #20000;
    errors++;
    tally_and_finish;
  end

  initial
  begin
    reset_n = 0;
    addr = 8'h00;
    bm = 0;
    wr = 0;
    rd = 0;
    rmw = 0;
    wd = 8'h00;
    ext_en = 0;
    ext_val = 8'h00;
    repeat (5) @(posedge clk);
    #1;
    reset_n = 1;
    chk("outs", {o0, o1, o2, o3}, 32'hffffffff);
    chk("ctl", {wpu, xbe, cse}, 3'b100);
    acc(8'he3, 0, 0, 1, 0, 8'h00);
    chk("route_b", rdata, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
      acc(8'h80 + 8'(i * 16), 0, 1, 0, 0, 8'h5a ^ 8'(i));
    chk("outs", {o0, o1, o2, o3}, 32'h5a5b5859);
    idle(3);
    for (int i = 0; i < 4; i++)
    begin
      acc(8'h80 + 8'(i * 16), 0, 0, 1, 0, 8'h00);
      chk("port_rd", rdata, 8'h5a ^ 8'(i));
    end
    $display("byte test done");
    ext_val = 8'h3c;
    ext_en = 1;
    idle(3);
    acc(8'h80, 0, 0, 1, 0, 8'h00);
    chk("pin_rd", rdata, 8'h3c);
    acc(8'h80, 0, 0, 1, 1, 8'h00);
    chk("latch_rd", rdata, 8'h5a);
    acc(8'h83, 1, 1, 1, 1, 8'h00);
    chk("clr_rd", rdata, 8'h01);
    chk("clr_out", o0, 8'h52);
    acc(8'h87, 1, 1, 1, 1, 8'h01);
    chk("set_rd", rdata, 8'h00);
    chk("set_out", o0, 8'hd2);
    acc(8'h82, 1, 0, 1, 0, 8'h00);
    chk("bit_pin", rdata, 8'h01);
    acc(8'ha0, 0, 0, 1, 1, 8'h00);
    chk("rmw_p2", rdata, 8'h58);
    acc(8'hb0, 0, 1, 0, 0, 8'ha5);
    acc(8'hb0, 0, 0, 1, 1, 8'h00);
    chk("unpinned_rmw", rdata, 8'ha5);
    acc(8'hb6, 1, 1, 0, 0, 8'h01);
    chk("set_p3", o3, 8'he5);
    $display("rmw test done");
    acc(8'he3, 0, 1, 0, 0, 8'hff);
    chk("ctl", {wpu, xbe, cse}, 3'b011);
    acc(8'he3, 1, 1, 0, 0, 8'h00);
    acc(8'he3, 0, 0, 1, 0, 8'h00);
    chk("route_b", rdata, 8'hc1);
    acc(8'h55, 0, 0, 1, 0, 8'h00);
    chk("unmapped", rdata, 8'h00);
    acc(8'he3, 0, 1, 0, 0, 8'h00);
    chk("ctl", {wpu, xbe, cse}, 3'b100);
    acc(8'he3, 0, 1, 0, 0, 8'hff);
    chk("ctl", {wpu, xbe, cse}, 3'b011);
    reset_n = 0;
    idle(2);
    reset_n = 1;
    chk("ctl", {wpu, xbe, cse}, 3'b100);
    chk("outs", {o0, o1, o2, o3}, 32'hffffffff);
    $display("control test done");
    tally_and_finish;
  end
endmodule

`default_nettype wire
